/* File: core/io_cmd_map.vh */
// Constants of the protection unit I/O command handler
`ifndef IO_CMD_MAP_VH
`define IO_CMD_MAP_VH
`define FC_DISPATCH      6'h21
`define FC_DEVICE_ID     6'h26
`define FC_INVAL_ALL     6'h27
`define FC_INVAL_SEG     6'h29
`define FC_INVAL_PAGE    6'h2B
`define FC_INVAL_IOMEM   6'h2D
`define CHAN_UNIT_LO     10'h010
`define CHAN_UNIT_HI     10'h01F
`define RING_KERNEL      3'h0
// Identity value is arbitrary
`define DEVICE_ID_VALUE  16'hA5C3
`define BASE_BOOT_VALUE  24'h000100
`define REG_BASE_LO      4'h0
`define REG_BASE_HI      4'h1
`define REG_STATUS       4'h2
`define REG_IDENT        4'h3
`define FWD_WORDS        3'h4
`define USED_BIT         0
`define MOD_BIT          1
`endif

/* File: core/protection_unit_io_command_handler.v */
// Function code decode, descriptor updates and peer forwarding of the protection unit
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "io_cmd_map.vh"

module protection_unit_io_command_handler #(
  parameter CHAN_W  = 10,
  parameter BASE_W  = 24,
  parameter DESC_W  = 16,
  parameter COUNT_W = 8
) (
  input  wire                sys_clk,
  input  wire                srst,
  // Command from own processor or peer units
  input  wire                cmdValid,
  input  wire                cmdAbsolute,
  input  wire [5:0]          cmdFunction,
  input  wire [CHAN_W-1:0]   cmdChannel,
  input  wire [15:0]         cmdData,
  input  wire [2:0]          currentRing,
  input  wire [CHAN_W-1:0]   ownChannel,
  // Register-style port
  input  wire [3:0]          regAddr,
  input  wire [15:0]         regWrData,
  input  wire                regWrite,
  input  wire                regRead,
  output reg  [15:0]         regRdData,
  // Command results
  output reg                 inputValid,
  output reg  [15:0]         inputData,
  output reg                 dispatchPulse,
  output reg  [15:0]         dispatchData,
  output reg                 mediateReq,
  output reg  [5:0]          mediateFunction,
  output reg                 invalAll,
  output reg                 invalSeg,
  output reg                 invalPage,
  output reg                 invalIoMem,
  output reg  [15:0]         invalTag,
  // Io load order and forwarding
  input  wire                loadOrder,
  input  wire [3:0]          descUnitChannel,
  input  wire [2:0]          effRing,
  input  wire [DESC_W-1:0]   memDescriptor,
  input  wire [CHAN_W-1:0]   loadChannel,
  output reg                 loadProceed,
  output reg                 fwdValid,
  output reg  [CHAN_W-1:0]   fwdTarget,
  output reg  [2:0]          fwdIndex,
  output reg  [BASE_W-1:0]   fwdWord,
  // Descriptor update (locked read-modify-write)
  input  wire                updReq,
  input  wire                updWrite,
  input  wire                memAck,
  input  wire [DESC_W-1:0]   memRdData,
  output reg                 memLock,
  output reg                 memRead,
  output reg                 memWrite,
  output reg  [DESC_W-1:0]   memWrData,
  output reg                 updDone,
  // Bootstrap state
  output reg  [2:0]          ringState,
  output reg  [BASE_W-1:0]   descBase,
  output reg                 translateAll
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function chanInRange;
    input [CHAN_W-1:0] c;
    begin
      chanInRange = (c >= `CHAN_UNIT_LO) && (c <= `CHAN_UNIT_HI);
    end
  endfunction

  // Peer channel named by the descriptor, placed in the unit band
  function [CHAN_W-1:0] peerTarget;
    input [3:0] low;
    begin
      peerTarget = `CHAN_UNIT_LO | {{(CHAN_W-4){1'b0}}, low};
    end
  endfunction

  // ----------------------------------------
  // Command acceptance
  // ----------------------------------------
  // Own channel outside the unit band never matches, so a bad strap ignores ring-0 processor commands; peer commands still execute
  wire chanMatch = (cmdChannel == ownChannel) && chanInRange(ownChannel);
  wire kernelCmd = !cmdAbsolute && (currentRing == `RING_KERNEL);
  // Peer commands carry no permission or mapping check
  wire execCmd   = cmdValid && (cmdAbsolute || (kernelCmd && chanMatch));
  wire outputDir = cmdFunction[0];

  always @(posedge sys_clk) begin
    if (srst) begin
      inputValid      <= 1'b0;
      inputData       <= 16'h0000;
      dispatchPulse   <= 1'b0;
      dispatchData    <= 16'h0000;
      mediateReq      <= 1'b0;
      mediateFunction <= 6'h00;
      invalAll        <= 1'b0;
      invalSeg        <= 1'b0;
      invalPage       <= 1'b0;
      invalIoMem      <= 1'b0;
      invalTag        <= 16'h0000;
    end else begin
      inputValid    <= 1'b0;
      dispatchPulse <= 1'b0;
      mediateReq    <= 1'b0;
      invalAll      <= 1'b0;
      invalSeg      <= 1'b0;
      invalPage     <= 1'b0;
      invalIoMem    <= 1'b0;
      if (cmdValid && !cmdAbsolute && (currentRing != `RING_KERNEL)) begin
        mediateReq      <= 1'b1;
        mediateFunction <= cmdFunction;
      end
      if (execCmd) begin
        case (cmdFunction)
          `FC_DISPATCH: begin
            dispatchPulse <= 1'b1;
            dispatchData  <= cmdData;
          end
          `FC_DEVICE_ID: begin
            if (!outputDir) begin
              inputValid <= 1'b1;
              inputData  <= `DEVICE_ID_VALUE;
            end
          end
          `FC_INVAL_ALL: invalAll <= 1'b1;
          `FC_INVAL_SEG: begin
            invalSeg <= 1'b1;
            invalTag <= cmdData;
          end
          `FC_INVAL_PAGE: begin
            invalPage <= 1'b1;
            invalTag  <= cmdData;
          end
          `FC_INVAL_IOMEM: begin
            invalIoMem <= 1'b1;
            invalTag   <= cmdData;
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Load order check and peer forwarding
  // ----------------------------------------
  // Forward sequence: base register, ring, channel, memory descriptor
  reg                fwdBusy;
  reg [2:0]          fwdSlot;
  reg [BASE_W-1:0]   fwdBase;
  reg [2:0]          fwdRing;
  reg [CHAN_W-1:0]   fwdChan;
  reg [DESC_W-1:0]   fwdDesc;
  reg [BASE_W-1:0]   next_fwdWord;

  always @* begin
    case (fwdSlot)
      3'h0:    next_fwdWord = fwdBase;
      3'h1:    next_fwdWord = {{(BASE_W-3){1'b0}}, fwdRing};
      3'h2:    next_fwdWord = {{(BASE_W-CHAN_W){1'b0}}, fwdChan};
      default: next_fwdWord = {{(BASE_W-DESC_W){1'b0}}, fwdDesc};
    endcase
  end

  // ----------------------------------------
  // Forward sequencer
  // ----------------------------------------
  // Index leaves with its own word so the peer can tell the four apart
  always @(posedge sys_clk) begin
    if (srst) begin
      loadProceed <= 1'b0;
      fwdValid    <= 1'b0;
      fwdBusy     <= 1'b0;
      fwdSlot     <= 3'h0;
      fwdTarget   <= {CHAN_W{1'b0}};
      fwdIndex    <= 3'h0;
      fwdWord     <= {BASE_W{1'b0}};
      fwdBase     <= {BASE_W{1'b0}};
      fwdRing     <= 3'h0;
      fwdChan     <= {CHAN_W{1'b0}};
      fwdDesc     <= {DESC_W{1'b0}};
    end else begin
      loadProceed <= 1'b0;
      fwdValid    <= 1'b0;
      if (fwdBusy) begin
        fwdValid <= 1'b1;
        fwdWord  <= next_fwdWord;
        fwdIndex <= fwdSlot;
        if (fwdSlot == `FWD_WORDS - 3'h1) begin
          fwdBusy <= 1'b0;
        end
        fwdSlot  <= fwdSlot + 3'h1;
      end else if (loadOrder) begin
        if (ownChannel[3:0] == descUnitChannel) begin
          loadProceed <= 1'b1;
        end else begin
          // Peer on the device's bus does the mediation
          fwdBusy   <= 1'b1;
          fwdSlot   <= 3'h0;
          fwdTarget <= peerTarget(descUnitChannel);
          fwdBase   <= descBase;
          fwdRing   <= effRing;
          fwdChan   <= loadChannel;
          fwdDesc   <= memDescriptor;
        end
      end
    end
  end

  // ----------------------------------------
  // Locked descriptor update
  // ----------------------------------------
  localparam ST_IDLE  = 4'b0001;
  localparam ST_READ  = 4'b0010;
  localparam ST_WRITE = 4'b0100;
  localparam ST_DONE  = 4'b1000;

  reg [3:0]        updState;
  reg [DESC_W-1:0] next_desc;
  reg              updIsWrite;

  wire updBusy = (updState != ST_IDLE);

  // ----------------------------------------
  // Descriptor merge
  // ----------------------------------------
  // Only used, modified and count fields are ever touched
  always @* begin
    next_desc = memRdData;
    next_desc[`USED_BIT] = 1'b1;
    if (updIsWrite) begin
      next_desc[`MOD_BIT] = 1'b1;
    end
    next_desc[DESC_W-1 -: COUNT_W] = memRdData[DESC_W-1 -: COUNT_W] + {{(COUNT_W-1){1'b0}}, 1'b1};
  end

  // ----------------------------------------
  // Update sequencer
  // ----------------------------------------
  // A request while a sequence runs is ignored
  always @(posedge sys_clk) begin
    if (srst) begin
      updState   <= ST_IDLE;
      updIsWrite <= 1'b0;
      memLock    <= 1'b0;
      memRead    <= 1'b0;
      memWrite   <= 1'b0;
      memWrData  <= {DESC_W{1'b0}};
      updDone    <= 1'b0;
    end else begin
      updDone <= 1'b0;
      case (updState)
        ST_IDLE: begin
          if (updReq) begin
            updIsWrite <= updWrite;
            memLock    <= 1'b1;
            memRead    <= 1'b1;
            updState   <= ST_READ;
          end
        end
        ST_READ: begin
          if (memAck) begin
            memRead   <= 1'b0;
            memWrite  <= 1'b1;
            memWrData <= next_desc;
            updState  <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (memAck) begin
            memWrite <= 1'b0;
            // Lock released only after the write lands
            memLock  <= 1'b0;
            updState <= ST_DONE;
          end
        end
        ST_DONE: begin
          updDone  <= 1'b1;
          updState <= ST_IDLE;
        end
        default: updState <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Bootstrap state
  // ----------------------------------------
  // No interrupt path exists; save area and return need no special case
  // Ring follows the processor once out of reset
  always @(posedge sys_clk) begin
    if (srst) begin
      ringState    <= `RING_KERNEL;
      translateAll <= 1'b1;
    end else begin
      ringState    <= currentRing;
      translateAll <= 1'b1;
    end
  end

  // ----------------------------------------
  // Descriptor base register writes
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (srst) begin
      descBase <= `BASE_BOOT_VALUE;
    end else begin
      if (regWrite && (regAddr == `REG_BASE_LO)) begin
        descBase[15:0] <= regWrData;
      end
      if (regWrite && (regAddr == `REG_BASE_HI)) begin
        descBase[BASE_W-1:16] <= regWrData[BASE_W-17:0];
      end
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  // Read data stands one cycle only, zero otherwise
  // Status: busy, forwarding, translate, ring
  wire [15:0] statusWord = {9'h000, updBusy, fwdBusy, translateAll, 1'b0, ringState};
  reg  [15:0] next_regRdData;

  always @* begin
    next_regRdData = 16'h0000;
    if (regRead) begin
      case (regAddr)
        `REG_BASE_LO: next_regRdData = descBase[15:0];
        `REG_BASE_HI: next_regRdData = {{(32-BASE_W){1'b0}}, descBase[BASE_W-1:16]};
        `REG_STATUS:  next_regRdData = statusWord;
        `REG_IDENT:   next_regRdData = `DEVICE_ID_VALUE;
        default:      next_regRdData = 16'h0000;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= next_regRdData;
    end
  end

endmodule // protection_unit_io_command_handler

/* File: testbench/mem_partner.sv */
// Memory partner answering the locked descriptor update
`timescale 1ns/100ps
module mem_partner (
  input  wire        sys_clk,
  input  wire        slow,
  input  wire        memRead,
  input  wire        memWrite,
  input  wire [15:0] memWrData,
  input  wire [15:0] initWord,
  output reg         memAck = 1'h0,
  output reg  [15:0] memRdData = 16'h0000,
  output reg  [15:0] lastWrite = 16'h0000
);
  reg [1:0] tick = 2'h0;
  always @(posedge sys_clk) begin
    tick <= tick + 2'h1;
    // Slow mode withholds the answer two cycles out of four
    memAck <= (memRead | memWrite) & ~memAck & ~(slow & tick[1]);
    // Idle data keeps toggling so a stale sample never looks right
    memRdData <= memRead ? initWord : ~memRdData;
    if (memWrite & memAck)
      lastWrite <= memWrData;
  end
endmodule // mem_partner

/* File: testbench/pu_checker_properties.sv */
// Port assertions for the protection unit command handler
`timescale 1ns/100ps
`include "io_cmd_map.vh"
module pu_checker (
  input wire        sys_clk,
  input wire        srst,
  input wire        cmdValid,
  input wire        cmdAbsolute,
  input wire [5:0]  cmdFunction,
  input wire [9:0]  cmdChannel,
  input wire [2:0]  currentRing,
  input wire [9:0]  ownChannel,
  input wire        inputValid,
  input wire [15:0] inputData,
  input wire        dispatchPulse,
  input wire        mediateReq,
  input wire        invalAll,
  input wire        invalSeg,
  input wire        invalPage,
  input wire        memLock,
  input wire        memRead,
  input wire        memWrite,
  input wire [2:0]  ringState,
  input wire [23:0] descBase
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire absCmd = cmdValid & cmdAbsolute;
  wire ring0 = cmdValid & ~cmdAbsolute & (currentRing == `RING_KERNEL);
  wire quiet = ~(inputValid | dispatchPulse | invalAll | mediateReq);
  wire listed = cmdFunction inside {6'h21, 6'h26, 6'h27, 6'h29, 6'h2B, 6'h2D};
  sequence locked_write;
    memWrite && memLock;
  endsequence
  id_reply_a: assert property (absCmd && cmdFunction == `FC_DEVICE_ID |=>
    inputValid && inputData == `DEVICE_ID_VALUE) else $error("identity reply wrong");
  dispatch_go_a: assert property (absCmd && cmdFunction == `FC_DISPATCH |=>
    dispatchPulse && !invalAll) else $error("dispatch missing");
  inval_all_a: assert property (absCmd && cmdFunction == `FC_INVAL_ALL |=>
    invalAll && !dispatchPulse) else $error("invalidate all missing");
  inval_page_a: assert property (absCmd && cmdFunction == `FC_INVAL_PAGE |=>
    invalPage && !invalSeg) else $error("page invalidate missing");
  ring_mediate_a: assert property (cmdValid && !cmdAbsolute &&
    currentRing != `RING_KERNEL |=> mediateReq && !inputValid) else $error("no mediation");
  chan_reject_a: assert property (ring0 && cmdChannel != ownChannel |=> quiet)
    else $error("foreign channel executed");
  unlisted_quiet_a: assert property (absCmd && !listed |=> quiet)
    else $error("unlisted code acted");
  locked_rmw_a: assert property ($fell(memRead) |-> locked_write)
    else $error("write not locked after read");
  boot_state_a: assert property ($past(srst) |-> ringState == `RING_KERNEL &&
    descBase == `BASE_BOOT_VALUE) else $error("boot state wrong");
endmodule // pu_checker
bind protection_unit_io_command_handler pu_checker pu_checker_i (.sys_clk, .srst, .cmdValid,
  .cmdAbsolute, .cmdFunction, .cmdChannel, .currentRing, .ownChannel, .inputValid, .inputData,
  .dispatchPulse, .mediateReq, .invalAll, .invalSeg, .invalPage, .memLock, .memRead, .memWrite,
  .ringState, .descBase);

/* File: testbench/protection_unit_io_command_handler_tb.sv */
// Self-checking bench for the protection unit command handler
`timescale 1ns/100ps
`include "io_cmd_map.vh"
module protection_unit_io_command_handler_tb;
  logic        sys_clk = 1'h0, srst = 1'h1, cmdValid = 1'h0, cmdAbsolute = 1'h0, slow = 1'h0;
  logic        regWrite = 1'h0, regRead = 1'h0, loadOrder = 1'h0, updReq = 1'h0, updWrite = 1'h0;
  logic [2:0]  currentRing = 3'h0, fwdIndex, ringState;
  logic [3:0]  regAddr = 4'h0, descUnitChannel = 4'h0;
  logic [5:0]  cmdFunction = 6'h00, mediateFunction;
  logic [9:0]  cmdChannel = 10'h000, ownChannel = 10'h015, fwdTarget;
  logic [15:0] regWrData = 16'h0000, initWord = 16'h0000, memRdData, memWrData, lastWrite;
  logic [15:0] regRdData, inputData, dispatchData, invalTag, cmdData = 16'h0000;
  logic        inputValid, dispatchPulse, mediateReq, invalAll, invalSeg, invalPage, invalIoMem;
  logic        loadProceed, fwdValid, memLock, memRead, memWrite, updDone, translateAll, memAck;
  logic [23:0] fwdWord, descBase;
  int          errors = 0, num_checks = 0;
  wire  [6:0]  outs = {inputValid, dispatchPulse, mediateReq, invalAll, invalSeg, invalPage,
                       invalIoMem};
  wire  [1:0]  ev = {updDone, fwdValid};

  always #10 sys_clk = ~sys_clk;

  // Ring, descriptor and load channel stay fixed; unit channel 015 sits in the allowed band
  protection_unit_io_command_handler protection_unit_io_command_handler_i (.sys_clk, .srst,
    .cmdValid, .cmdAbsolute, .cmdFunction, .cmdChannel, .cmdData, .currentRing,
    .ownChannel, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .inputValid,
    .inputData, .dispatchPulse, .dispatchData, .mediateReq, .mediateFunction, .invalAll,
    .invalSeg, .invalPage, .invalIoMem, .invalTag, .loadOrder, .descUnitChannel,
    .effRing(3'h3), .memDescriptor(16'h5A3C), .loadChannel(10'h0C7), .loadProceed, .fwdValid,
    .fwdTarget, .fwdIndex, .fwdWord, .updReq, .updWrite, .memAck, .memRdData, .memLock,
    .memRead, .memWrite, .memWrData, .updDone, .ringState, .descBase, .translateAll);
  mem_partner mem_partner_i (.sys_clk, .slow, .memRead, .memWrite, .memWrData, .initWord,
    .memAck, .memRdData, .lastWrite);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic waitfor(input int which);
    for (int n = 0; n < 20 && ev[which] !== 1'h1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (ev[which] !== 1'h1) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, ev[which], 1'h1);
      tally_and_finish();
    end
  endtask

  task automatic cmd(input logic a, input logic [5:0] f, input logic [9:0] c, input logic [2:0] r);
    @(posedge sys_clk);
    {cmdValid, cmdAbsolute, cmdFunction, cmdChannel, currentRing} <= {1'h1, a, f, c, r};
    cmdData <= {c, f};
    @(posedge sys_clk);
    cmdValid <= 1'h0;
    #1;
  endtask

  task automatic reg_op(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    {regWrite, regRead, regAddr, regWrData} <= {w, ~w, a, d};
    @(posedge sys_clk);
    {regWrite, regRead} <= 2'h0;
    #1;
    if (!w)
      chk(regRdData, d);
  endtask

  task automatic t_boot;
    chk({ringState, descBase, translateAll}, {`RING_KERNEL, `BASE_BOOT_VALUE, 1'h1});
  endtask

  task automatic t_table;
    logic [5:0] fc[7] = '{6'h21, 6'h26, 6'h27, 6'h29, 6'h2B, 6'h2D, 6'h22};
    logic [6:0] ex[7] = '{7'h20, 7'h40, 7'h08, 7'h04, 7'h02, 7'h01, 7'h00};
    for (int i = 0; i < 7; i++) begin
      // Wrong channel and outer ring: peer commands must still execute
      cmd(1'h1, fc[i], 10'h3FF, 3'h5);
      chk(outs, ex[i]);
    end
    cmd(1'h1, `FC_DEVICE_ID, 10'h3FF, 3'h5);
    chk(inputData, `DEVICE_ID_VALUE);
    // Data of the last dispatch and of the last selective invalidate
    chk({dispatchData, invalTag}, {10'h3FF, 6'h21, 10'h3FF, 6'h2D});
  endtask

  task automatic t_virtual;
    cmd(1'h0, `FC_DEVICE_ID, 10'h015, `RING_KERNEL);
    chk(outs, 7'h40);
    cmd(1'h0, `FC_DEVICE_ID, 10'h016, `RING_KERNEL);
    chk(outs, 7'h00);
    // Matching channel outside the unit band must not execute
    @(posedge sys_clk);
    ownChannel <= 10'h005;
    cmd(1'h0, `FC_DEVICE_ID, 10'h005, `RING_KERNEL);
    chk(outs, 7'h00);
    @(posedge sys_clk);
    ownChannel <= 10'h015;
    cmd(1'h0, `FC_INVAL_ALL, 10'h015, 3'h2);
    chk({outs, mediateFunction}, {7'h10, `FC_INVAL_ALL});
  endtask

  task automatic t_load;
    logic [23:0] w[4] = '{`BASE_BOOT_VALUE, 24'h000003, 24'h0000C7, 24'h005A3C};
    for (int u = 5; u < 11; u += 5) begin
      @(posedge sys_clk);
      {loadOrder, descUnitChannel} <= {1'h1, u[3:0]};
      @(posedge sys_clk);
      loadOrder <= 1'h0;
      #1;
      chk(loadProceed, u == 5);
    end
    waitfor(0);
    chk(fwdTarget, 10'h01A);
    for (int k = 0; k < 4; k++) begin
      chk({fwdValid, fwdIndex, fwdWord}, {1'h1, k[2:0], w[k]});
      @(posedge sys_clk);
      #1;
    end
  endtask

  task automatic t_upd(input logic s, input logic w, input logic [15:0] d, input logic [15:0] e);
    @(posedge sys_clk);
    {slow, updWrite, initWord, updReq} <= {s, w, d, 1'h1};
    @(posedge sys_clk);
    updReq <= 1'h0;
    waitfor(1);
    chk({memLock, lastWrite}, {1'h0, e});
  endtask

  task automatic t_regs;
    reg_op(1'h1, 4'h0, 16'h1234);
    reg_op(1'h1, 4'h1, 16'h00AB);
    reg_op(1'h1, 4'hF, 16'hFFFF);
    reg_op(1'h0, 4'h0, 16'h1234);
    reg_op(1'h0, 4'h1, 16'h00AB);
    // Ring 2 of the last processor command still shows in the status
    reg_op(1'h0, 4'h2, 16'h0012);
    reg_op(1'h0, 4'h3, `DEVICE_ID_VALUE);
  endtask

  task tally_and_finish;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    #1;
    t_boot();
    t_table();
    t_virtual();
    t_load();
    t_upd(1'h0, 1'h1, 16'h12F0, 16'h13F3);
    t_upd(1'h1, 1'h0, 16'hFFF0, 16'h00F1);
    t_regs();
    tally_and_finish();
  end
endmodule // protection_unit_io_command_handler_tb
